// file: inc/pdsb_map.vh
`ifndef PDSB_MAP_VH
`define PDSB_MAP_VH
// ----------------------------------------
// target address and timing
// ----------------------------------------
`define PDSB_I2C_ADDR        7'h38
`define PDSB_RST_HOLD_NS     100000
`define PDSB_CLK_PERIOD_NS   10
`define PDSB_RST_HOLD_CYC \
  ((`PDSB_RST_HOLD_NS + `PDSB_CLK_PERIOD_NS - 1) / `PDSB_CLK_PERIOD_NS)
// ----------------------------------------
// power object values, 10 mV and 10 mA units
// ----------------------------------------
`define PDSB_MV_5V           10'h1F4
`define PDSB_MV_9V           10'h384
`define PDSB_MV_15V          10'h5DC
`define PDSB_MV_20V          10'h7D0
`define PDSB_MA_1P5A         10'h096
`define PDSB_MA_3A           10'h12C
`define PDSB_MA_5A           10'h1F4
// ----------------------------------------
// status byte field positions
// ----------------------------------------
`define PDSB_ST_ATTACHED     0
`define PDSB_ST_FLIP         1
`define PDSB_ST_USB3         2
`define PDSB_ST_VIDEO        3
`define PDSB_ST_HOST_MUX     4
`define PDSB_ST_CFG_DONE     5
`define PDSB_ST_RST_OFF      6
`endif

// file: rtl/pdsb_sideband.v
// Operation
// RL1 - three mux outputs follow orientation, usb3 and video selection.
// RL2 - the outside mux is strapped so only these outputs pick its routing.
// RL3 - once the connection is known an interrupt is raised to the host.
// RL4 - the host answers the interrupt by reading status over i2c.
// RL5 - the secondary target i2c port answers to 7-bit address 0x38.
// RL6 - the flash is used by one party at a time, device first, host after.
// RL7 - the host is held in reset until configuration load finishes.
// RL8 - output zero is only the host reset and carries no other event.
// RL9 - outside logic ands the reset with the host 3.3 V rail good.
// RL10 - reset releases no sooner than 100 us after the host rail is up.
// RL11 - the embedded controller may hold release until system boot is done.
// RL12 - the video notebook profile offers one source object of 5 V 1.5 A.
// RL13 - the fast host profile offers one source object of 5 V 3 A.
// RL14 - sink objects are 5, 9, 15 and 20 V at 3 A, 5 A max at 20 V.
// RL15 - video runs as source facing with pin sets c, d, e; usb is host.
// RL16 - when the host muxes lanes itself the outside mux is not driven.
// RL17 - the host reset is active low from power on until config is done.
`include "pdsb_map.vh"
module pdsb_sideband #(
  parameter RST_HOLD_CYC = `PDSB_RST_HOLD_CYC
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        attached,
  input  wire        plug_flip,
  input  wire        usb3_req,
  input  wire        video_req,
  input  wire [1:0]  video_pin_set,
  input  wire        host_does_mux,
  input  wire        fast_host_profile,
  input  wire        cfg_done,
  input  wire        host_ctrl_3v3_rail,
  input  wire        boot_gate_en,
  input  wire        system_booted,
  input  wire        int_ack,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  output reg         flash_own_device,
  output reg         flash_own_host,
  output reg         host_ctrl_reset_line_b,
  output reg         mux_flip,
  output reg         mux_usb3_select,
  output reg         mux_video_select,
  output reg         host_int_b,
  output reg         video_source_facing_port,
  output reg         usb_host_role,
  output reg  [19:0] src_pdo,
  output reg  [79:0] snk_pdo
);
  localparam S_IDLE = 5'h01;
  localparam S_ADDR = 5'h02;
  localparam S_AACK = 5'h04;
  localparam S_DATA = 5'h08;
  localparam S_DACK = 5'h10;
  localparam CW = 24;
  localparam [CW-1:0] HOLD = RST_HOLD_CYC[CW-1:0];
  // ----------------------------------------
  // reset hold and flash ownership
  // ----------------------------------------
  reg [CW-1:0] hold_reg;
  wire hold_ok = (hold_reg >= HOLD);
  wire release_ok = cfg_done && hold_ok && (!boot_gate_en || system_booted);
  // counts only while rail good; drop restarts the wait
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_reg <= {CW{1'b0}};
    end else if (!host_ctrl_3v3_rail) begin
      hold_reg <= {CW{1'b0}}; // see RL10
    end else if (!hold_ok) begin
      hold_reg <= hold_reg + 1'b1;
    end
  end
  // device owns flash and keeps host in reset until load done
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_ctrl_reset_line_b <= 1'b0; // see RL17
      flash_own_device       <= 1'b1;
      flash_own_host         <= 1'b0;
    end else begin
      host_ctrl_reset_line_b <= release_ok; // see RL7, RL8, RL11
      flash_own_device       <= !cfg_done; // see RL6
      flash_own_host         <= release_ok && !flash_own_device; // see RL6
    end
  end
  // ----------------------------------------
  // mux events, roles, power objects
  // ----------------------------------------
  wire drive_mux = attached && !host_does_mux;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_flip                 <= 1'b0;
      mux_usb3_select          <= 1'b0;
      mux_video_select         <= 1'b0;
      video_source_facing_port <= 1'b0;
      usb_host_role            <= 1'b0;
      src_pdo                  <= 20'h00000;
      snk_pdo                  <= 80'h0;
    end else begin
      mux_flip         <= drive_mux && plug_flip; // see RL1, RL16
      mux_usb3_select  <= drive_mux && usb3_req; // see RL1, RL16
      mux_video_select <= drive_mux && video_req; // see RL1, RL16
      // pin sets c, d, e coded 1..3; 0 is not offered
      video_source_facing_port <= attached && video_req &&
                                  (video_pin_set != 2'h0); // see RL15
      usb_host_role    <= attached && usb3_req; // see RL15
      // voltage high, current low in each 20-bit object
      src_pdo <= fast_host_profile ?
                 {`PDSB_MV_5V, `PDSB_MA_3A} : // see RL13
                 {`PDSB_MV_5V, `PDSB_MA_1P5A}; // see RL12
      snk_pdo <= {`PDSB_MV_20V, `PDSB_MA_5A, `PDSB_MV_15V, `PDSB_MA_3A,
                  `PDSB_MV_9V, `PDSB_MA_3A, `PDSB_MV_5V, `PDSB_MA_3A}; // see RL14
    end
  end
  // ----------------------------------------
  // interrupt on connection change
  // ----------------------------------------
  reg       rd_done; // pulsed by the i2c target below
  reg [3:0] conn_reg;
  wire [3:0] conn_now = {attached, plug_flip, usb3_req, video_req};
  wire conn_chg = (conn_now != conn_reg);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conn_reg   <= 4'h0;
      host_int_b <= 1'b1;
    end else begin
      conn_reg <= conn_now;
      // new change wins over acknowledge or status read
      if (conn_chg) begin
        host_int_b <= 1'b0; // see RL3
      end else if (int_ack || rd_done) begin
        host_int_b <= 1'b1; // see RL4
      end
    end
  end
  // ----------------------------------------
  // i2c target, read of status byte only
  // ----------------------------------------
  reg scl_d_reg;
  reg sda_d_reg;
  reg [4:0] st_reg;
  reg [3:0] bit_reg;
  reg [7:0] sr_reg;
  reg       rw_reg;
  wire scl_rise = scl_in && !scl_d_reg;
  wire scl_fall = !scl_in && scl_d_reg;
  wire start_c  = scl_in && scl_d_reg && sda_d_reg && !sda_in;
  wire stop_c   = scl_in && scl_d_reg && !sda_d_reg && sda_in;
  wire [7:0] status_byte = {1'b0, host_ctrl_reset_line_b, cfg_done,
                            host_does_mux, video_req, usb3_req,
                            plug_flip, attached};
  // load at the address match so the first bit is ready at the ack fall;
  // reload when the master acks for another byte
  wire tx_load  = ((st_reg == S_ADDR) && scl_fall && (bit_reg == 4'h8) &&
                   (sr_reg[7:1] == `PDSB_I2C_ADDR) && sr_reg[0]) ||
                  ((st_reg == S_DACK) && scl_rise && !sda_in);
  wire tx_shift = ((st_reg == S_AACK) || (st_reg == S_DATA)) && scl_fall;
  wire tx_bit;
  pdsb_status_shift #(.W(8)) u_shift (
    .clk       (clk),
    .rst_b     (rst_b),
    .load      (tx_load),
    .load_data (status_byte),
    .shift     (tx_shift),
    .bit_out   (tx_bit)
  );
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      st_reg    <= S_IDLE;
      bit_reg   <= 4'h0;
      sr_reg    <= 8'h00;
      rw_reg    <= 1'b0;
      rd_done   <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
    end else begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
      rd_done   <= 1'b0;
      sda_out   <= 1'b0;
      if (start_c) begin
        st_reg  <= S_ADDR;
        bit_reg <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        st_reg <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_reg)
          S_IDLE: sda_oe <= 1'b0;
          S_ADDR: begin
            if (scl_rise) begin
              sr_reg  <= {sr_reg[6:0], sda_in};
              bit_reg <= bit_reg + 1'b1;
            end
            if (scl_fall && bit_reg == 4'h8) begin
              if (sr_reg[7:1] == `PDSB_I2C_ADDR) begin // see RL5
                rw_reg <= sr_reg[0];
                sda_oe <= 1'b1;
                st_reg <= S_AACK;
              end else begin
                st_reg <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              bit_reg <= 4'h0;
              sda_oe  <= rw_reg && !tx_bit;
              // a write has only its address acked, then its data bytes are nacked and ignored
              st_reg  <= rw_reg ? S_DATA : S_IDLE;
            end
          end
          S_DATA: begin
            if (scl_rise) begin
              bit_reg <= bit_reg + 1'b1;
            end
            if (scl_fall) begin
              sda_oe <= (bit_reg != 4'h8) && !tx_bit;
              if (bit_reg == 4'h8) begin
                st_reg <= S_DACK;
              end
            end
          end
          S_DACK: begin
            if (scl_rise) begin
              rd_done <= 1'b1; // see RL4
              bit_reg <= 4'h0;
              st_reg  <= sda_in ? S_IDLE : S_DATA;
            end
          end
          default: st_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule // pdsb_sideband

// file: rtl/pdsb_status_shift.v
// ----------------------------------------
// status byte shifter for i2c reads
// ----------------------------------------
module pdsb_status_shift #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         load,
  input  wire [W-1:0] load_data,
  input  wire         shift,
  output reg          bit_out
);
  reg [W-1:0] sh_reg;
  // msb first, load wins over shift
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_reg  <= {W{1'b0}};
      bit_out <= 1'b0;
    end else if (load) begin
      sh_reg  <= {load_data[W-2:0], 1'b0};
      bit_out <= load_data[W-1];
    end else if (shift) begin
      sh_reg  <= {sh_reg[W-2:0], 1'b0};
      bit_out <= sh_reg[W-1];
    end
  end
endmodule // pdsb_status_shift

// file: tb/pdsb_host_model.sv
// ----------------------------------------
// host controller side: i2c reader of status
// ----------------------------------------
module pdsb_host_model (
  input  wire  clk,
  input  wire  sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idles released, pull-up keeps it high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // five clocks per phase, over the two the port needs
  task automatic wt();
    repeat (5) @(posedge clk);
    #1;
  endtask
  // data moves only while scl is low
  task automatic bitx(input logic b, output logic s);
    wt();
    sda_low = !b;
    wt();
    scl = 1'b1;
    wt();
    s = sda;
    scl = 1'b0;
  endtask
  // one read byte, then nack and stop
  task automatic rd(input logic [6:0] a, output logic ack,
                    output logic [7:0] d);
    logic s;
    sda_low = 1'b1;
    wt();
    scl = 1'b0;
    for (int i = 6; i >= 0; i--) bitx(a[i], s);
    bitx(1'b1, s);
    bitx(1'b1, s);
    ack = !s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, s);
    wt();
    sda_low = 1'b1;
    wt();
    scl = 1'b1;
    wt();
    sda_low = 1'b0;
  endtask
endmodule // pdsb_host_model

// file: tb/pdsb_sideband_bench.sv
// ----------------------------------------
// sideband bench
// ----------------------------------------
module pdsb_sideband_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  logic clk, rst_b, attached, plug_flip, usb3_req, video_req, host_does_mux;
  logic fast_host_profile, cfg_done, host_ctrl_3v3_rail, boot_gate_en;
  logic system_booted, int_ack, ack;
  logic [1:0] video_pin_set;
  logic [7:0] d;
  wire scl_in, sda_low, sda_out, sda_oe, flash_own_device, flash_own_host;
  wire host_ctrl_reset_line_b, mux_flip, mux_usb3_select, mux_video_select;
  wire host_int_b, video_source_facing_port, usb_host_role;
  wire [19:0] src_pdo;
  wire [79:0] snk_pdo;
  wire sda_line = !(sda_oe | sda_low); // pull-up when nobody pulls
  int fail_count, samples_checked, cyc;
  pdsb_sideband #(.RST_HOLD_CYC(HOLD)) pdsb_sideband_i (.clk, .rst_b,
    .attached, .plug_flip, .usb3_req, .video_req, .video_pin_set,
    .host_does_mux, .fast_host_profile, .cfg_done, .host_ctrl_3v3_rail,
    .boot_gate_en, .system_booted, .int_ack, .scl_in, .sda_in(sda_line),
    .sda_out, .sda_oe, .flash_own_device, .flash_own_host,
    .host_ctrl_reset_line_b, .mux_flip, .mux_usb3_select, .mux_video_select,
    .host_int_b, .video_source_facing_port, .usb_host_role, .src_pdo,
    .snk_pdo);
  pdsb_host_model pdsb_host_model_i (.clk, .sda(sda_line), .scl(scl_in),
    .sda_low);
  // helpers: compare, wait, close
  task automatic chk(string n, logic [79:0] seen, logic [79:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
      fail_count++;
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the fewer than a thousand cycles used
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    {rst_b, attached, plug_flip, usb3_req, video_req, host_does_mux} = 0;
    {fast_host_profile, cfg_done, host_ctrl_3v3_rail, boot_gate_en} = 0;
    {system_booted, int_ack, video_pin_set} = 0;
    repeat (20) @(posedge clk);
    chk("rst", host_ctrl_reset_line_b, 0);
    chk("fdev", flash_own_device, 1);
    chk("int", host_int_b, 1);
    #1 rst_b = 1'b1;
    host_ctrl_3v3_rail = 1'b1;
    tick(HOLD + 5);
    chk("rst_cfg", host_ctrl_reset_line_b, 0);
    {boot_gate_en, cfg_done} = 2'h3;
    tick(HOLD + 5);
    chk("fdev", flash_own_device, 0);
    chk("fhost", flash_own_host, 0);
    chk("rst_gate", host_ctrl_reset_line_b, 0);
    system_booted = 1'b1;
    tick(3);
    chk("rst_off", host_ctrl_reset_line_b, 1);
    chk("fhost", flash_own_host, 1);
    host_ctrl_3v3_rail = 1'b0;
    tick(3);
    chk("rst_drop", host_ctrl_reset_line_b, 0);
    host_ctrl_3v3_rail = 1'b1;
    tick(HOLD - 2);
    chk("rst_early", host_ctrl_reset_line_b, 0);
    tick(5);
    chk("rst_late", host_ctrl_reset_line_b, 1);
    {boot_gate_en, system_booted} = 2'h0;
    tick(2);
    chk("rst_nogate", host_ctrl_reset_line_b, 1);
    chk("src", src_pdo, {10'h1F4, 10'h096});
    fast_host_profile = 1'b1;
    tick(2);
    chk("src", src_pdo, {10'h1F4, 10'h12C});
    chk("snk", snk_pdo, {10'h7D0, 10'h1F4, 10'h5DC, 10'h12C, 10'h384,
        10'h12C, 10'h1F4, 10'h12C});
    video_pin_set = 2'h1;
    for (int i = 0; i < 32; i++) begin
      {attached, host_does_mux, video_req, usb3_req, plug_flip} = i[4:0];
      tick(2);
      chk("flip", mux_flip, attached & plug_flip & !host_does_mux);
      chk("u3", mux_usb3_select, attached & usb3_req & !host_does_mux);
      chk("vid", mux_video_select, attached & video_req & !host_does_mux);
      chk("host", usb_host_role, attached & usb3_req);
    end
    {attached, host_does_mux, video_req, usb3_req, plug_flip} = 5'h14;
    for (int p = 1; p < 4; p++) begin
      video_pin_set = p[1:0];
      tick(2);
      chk("vsf", video_source_facing_port, 1);
    end
    video_pin_set = 2'h0;
    tick(2);
    chk("vsf_none", video_source_facing_port, 0);
    chk("sda_idle", sda_out, 0);
    int_ack = 1'b1;
    tick(1);
    int_ack = 1'b0;
    tick(2);
    chk("int_ack", host_int_b, 1);
    plug_flip = 1'b1;
    tick(2);
    chk("int_set", host_int_b, 0);
    pdsb_host_model_i.rd(7'h38, ack, d);
    chk("ack", ack, 1);
    chk("status", d, 8'h6B);
    tick(2);
    chk("int_rd", host_int_b, 1);
    pdsb_host_model_i.rd(7'h39, ack, d);
    chk("nack", ack, 0);
    end_sim();
  end
endmodule // pdsb_sideband_bench

// file: tb/pdsb_sideband_chk.sv
// ----------------------------------------
// port checker
// ----------------------------------------
module pdsb_sideband_chk #(
  parameter int RST_HOLD_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic attached,
  input wire logic plug_flip,
  input wire logic usb3_req,
  input wire logic video_req,
  input wire logic host_does_mux,
  input wire logic cfg_done,
  input wire logic host_ctrl_3v3_rail,
  input wire logic flash_own_device,
  input wire logic flash_own_host,
  input wire logic host_ctrl_reset_line_b,
  input wire logic mux_flip,
  input wire logic mux_usb3_select,
  input wire logic mux_video_select,
  input wire logic host_int_b
);
  logic        run_reg;
  logic [15:0] rail_cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // first edge after reset still sees reset-time inputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_reg <= 1'b0;
      rail_cnt_reg <= 16'h0000;
    end else begin
      run_reg <= 1'b1;
      if (!host_ctrl_3v3_rail) rail_cnt_reg <= 16'h0000;
      else if (rail_cnt_reg != 16'hFFFF) rail_cnt_reg <= rail_cnt_reg + 16'h0001;
    end
  end
  property p_flip;
    run_reg |-> mux_flip == $past(attached & plug_flip & !host_does_mux);
  endproperty
  property p_usb3;
    run_reg |-> mux_usb3_select == $past(attached & usb3_req & !host_does_mux);
  endproperty
  property p_video;
    run_reg |-> mux_video_select == $past(attached & video_req & !host_does_mux);
  endproperty
  property p_hold;
    $rose(host_ctrl_reset_line_b) |-> rail_cnt_reg >= RST_HOLD_CYC;
  endproperty
  property p_cfg;
    !cfg_done |=> !host_ctrl_reset_line_b;
  endproperty
  property p_drop;
    $fell(host_ctrl_3v3_rail) |-> ##[1:2] !host_ctrl_reset_line_b;
  endproperty
  property p_excl;
    !(flash_own_device && flash_own_host);
  endproperty
  property p_int;
    run_reg && $changed({attached, plug_flip, usb3_req, video_req})
      |-> ##[0:2] !host_int_b;
  endproperty
  a_flip: assert property (p_flip) else $error("flip output wrong");
  a_usb3: assert property (p_usb3) else $error("usb3 output wrong");
  a_video: assert property (p_video) else $error("video output wrong");
  a_hold: assert property (p_hold) else $error("reset released early");
  a_cfg: assert property (p_cfg) else $error("reset off before config");
  a_drop: assert property (p_drop) else $error("rail loss kept reset off");
  a_excl: assert property (p_excl) else $error("flash owned twice");
  a_int: assert property (p_int) else $error("no interrupt on change");
  c_rel: cover property ($rose(host_ctrl_reset_line_b));
  c_vid: cover property (mux_video_select);
  c_int: cover property ($fell(host_int_b));
endmodule // pdsb_sideband_chk
bind pdsb_sideband pdsb_sideband_chk #(.RST_HOLD_CYC(RST_HOLD_CYC)) chk_i (
  .clk, .rst_b, .attached, .plug_flip, .usb3_req, .video_req,
  .host_does_mux, .cfg_done, .host_ctrl_3v3_rail, .flash_own_device,
  .flash_own_host, .host_ctrl_reset_line_b, .mux_flip, .mux_usb3_select,
  .mux_video_select, .host_int_b
);
